// file: hdl/ech_handler.sv
// transparent channel event and error handler with descriptor poster
// How it works
// - tx buffer end posts event, dir 1
// - no message-end code is ever posted
// - tx buffer end steps to next descriptor
// - rx buffer end posts event, dir 0
// - frame return posts recovery unless masked
// - tx host-owned buffer: ownership error, suspend
// - tx fifo underrun: error, idle, suspend
// - rx overflow, no buffer: error, flush, deactivate
// - rx overrun with buffer: error, flush, suspend
// - rx restart by activate, jump, table write
// - unexpected sync rise in framed modes: alignment error
// - abort flag picks keep or suspend on alignment
// - frame loss posts error, flushes rx fifo
// - frame loss, no abort: write ones, auto-resume
// - frame loss with abort: suspend, host reactivates
// - fcs 1 and protocol 2 select link protocol
// - empty and no owned buffer: error, idle
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

`include "ech_cfg.svh"

module ech_handler
  import ech_pkg::*;
(
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_reset,
  input  wire logic                   i_ce,
  input  wire logic [`ECH_ADDR_W-1:0] i_addr,
  input  wire logic [31:0]            i_wr_data,
  input  wire logic                   i_wr_en,
  input  wire logic                   i_rd_en,
  output logic      [31:0]            o_rd_data,
  input  wire logic                   i_link_clk,
  input  wire logic                   i_receive_frame_sync,
  input  wire logic                   i_frame_loss,
  input  wire logic                   i_tx_octet,
  input  wire logic [13:0]            i_tx_buffer_length_field,
  input  wire logic                   i_tx_buffer_end_event_enable,
  input  wire logic                   i_tx_desc_fetch,
  input  wire logic                   i_tx_dev_owns,
  input  wire logic                   i_tx_fifo_empty,
  input  wire logic                   i_tx_bit_need,
  input  wire logic                   i_rx_octet,
  input  wire logic [13:0]            i_rx_buffer_length_field,
  input  wire logic                   i_rx_buffer_end_event_enable,
  input  wire logic                   i_rx_fifo_ovf,
  input  wire logic                   i_rx_dev_owns,
  output logic                        o_tx_next_desc,
  output logic                        o_tx_idle_code,
  output logic                        o_tx_bus_en,
  output logic                        o_rx_next_desc,
  output logic                        o_rx_bus_en,
  output logic                        o_rx_store_en,
  output logic                        o_rx_fill_ones,
  output logic                        o_rx_flush,
  output logic                        o_intersystem_link_protocol,
  output logic                        o_idesc_valid,
  input  wire logic                   i_idesc_ready,
  output logic      [7:0]             o_idesc_chan,
  output logic      [3:0]             o_idesc_code,
  output logic                        o_idesc_dir
);

  localparam ech_state_s RST = '{
    tx_st: ECH_CH_OFF, rx_st: ECH_CH_OFF, tx_cnt: 14'h0000, rx_cnt: 14'h0000,
    pend: 9'h000, idv: 1'b0, idcode: ECH_C_NONE, iddir: 1'b0, tx_next: 1'b0,
    rx_flush: 1'b0, lclk_q: 1'b0, receive_frame_sync_q: 1'b0, oof_q: 1'b0, locked: 1'b0,
    bit_cnt: 11'h000, cfg: `ECH_CFG_RST, cct: `ECH_CCT_RST, rd_data: 32'h0000_0000};

  ech_state_s s_r;
  ech_state_s s_nxt;

  logic [2:0]            sy;
  logic [`ECH_NPEND-1:0] ev_set;
  logic [`ECH_NPEND-1:0] ev_clr;
  logic                  tx_run;
  logic                  rx_run;
  logic                  tx_done;
  logic                  rx_done;
  logic                  lclk_rise;
  logic                  sync_rise;
  logic                  oof_rise;
  logic                  oof_fall;
  logic                  framed;
  logic [10:0]           frm_last;
  logic                  abort;
  logic                  rx_restart;
  logic                  tx_onr;
  logic                  tx_fifo_run_error;
  logic                  rx_onr;
  logic                  rx_fifo_run_error;
  logic                  alignment_change_error;

  ech_sync #(
    .W(3)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_ce      (i_ce),
    .i_async   ({i_frame_loss, i_receive_frame_sync, i_link_clk}),
    .o_sync    (sy)
  );

  // frame length of the configured port mode
  always_comb begin
    framed   = 1'b1;
    frm_last = 11'h000;
    unique case (s_r.cfg[`ECH_F_MODE_HI:`ECH_F_MODE_LO])
      `ECH_MODE_T1:   frm_last = `ECH_FRM_T1 - 11'h001;
      `ECH_MODE_E1:   frm_last = `ECH_FRM_E1 - 11'h001;
      `ECH_MODE_E1X2: frm_last = `ECH_FRM_E1X2 - 11'h001;
      `ECH_MODE_E1X4: frm_last = `ECH_FRM_E1X4 - 11'h001;
      default:        framed = 1'b0;
    endcase
  end

  assign abort      = s_r.cfg[`ECH_F_ABORT];
  assign tx_run     = (s_r.tx_st == ECH_CH_RUN);
  assign rx_run     = (s_r.rx_st == ECH_CH_RUN);
  assign lclk_rise  = sy[0] & ~s_r.lclk_q;
  assign sync_rise  = lclk_rise & sy[1] & ~s_r.receive_frame_sync_q;
  assign oof_rise   = sy[2] & ~s_r.oof_q;
  assign oof_fall   = ~sy[2] & s_r.oof_q;
  assign tx_done    = tx_run & i_tx_octet & (s_r.tx_cnt + 14'h0001 >= i_tx_buffer_length_field);
  assign rx_done    = rx_run & i_rx_octet & (s_r.rx_cnt + 14'h0001 >= i_rx_buffer_length_field);
  // host-owned buffer when data is needed, or drained with nothing owned
  assign tx_onr     = tx_run & ~i_tx_dev_owns & (i_tx_desc_fetch | (i_tx_fifo_empty & i_tx_bit_need));
  assign tx_fifo_run_error    = tx_run & i_tx_dev_owns & i_tx_fifo_empty & i_tx_bit_need;
  assign rx_onr     = rx_run & i_rx_fifo_ovf & ~i_rx_dev_owns;
  assign rx_fifo_run_error    = rx_run & i_rx_fifo_ovf & i_rx_dev_owns;
  assign alignment_change_error       = sync_rise & framed & s_r.locked & (s_r.bit_cnt != frm_last);
  assign rx_restart = i_wr_en & ((i_addr == `ECH_ADDR_RXCCT) |
                      ((i_addr == `ECH_ADDR_CMD) &
                       (i_wr_data[`ECH_CMD_RXACT] | i_wr_data[`ECH_CMD_RXJUMP])));

  // events raised this cycle
  always_comb begin
    ev_set                = '0;
    ev_set[`ECH_P_TXEOB]  = tx_done & i_tx_buffer_end_event_enable;
    ev_set[`ECH_P_RXEOB]  = rx_done & i_rx_buffer_end_event_enable;
    ev_set[`ECH_P_FRAME_RECOVERED_EVENT]   = oof_fall & ~s_r.cfg[`ECH_F_MASK];
    ev_set[`ECH_P_TXONR]  = tx_onr;
    ev_set[`ECH_P_TXBUFF] = tx_fifo_run_error;
    ev_set[`ECH_P_RXONR]  = rx_onr;
    ev_set[`ECH_P_RXBUFF] = rx_fifo_run_error;
    ev_set[`ECH_P_ALIGNMENT_CHANGE_ERROR]   = alignment_change_error;
    ev_set[`ECH_P_OOF]    = oof_rise;
  end

  always_comb begin
    s_nxt          = s_r;
    ev_clr         = '0;
    s_nxt.tx_next  = 1'b0;
    s_nxt.rx_flush = 1'b0;
    s_nxt.rd_data  = 32'h0000_0000;

    // register port
    if (i_wr_en) begin
      unique case (i_addr)
        `ECH_ADDR_CFG: s_nxt.cfg = i_wr_data[15:0];
        `ECH_ADDR_CMD: begin
          if (i_wr_data[`ECH_CMD_TXACT]) begin
            s_nxt.tx_st  = ECH_CH_RUN;
            s_nxt.tx_cnt = 14'h0000;
          end
        end
        `ECH_ADDR_RXCCT: s_nxt.cct = i_wr_data[15:0];
        default: ;
      endcase
    end
    if (rx_restart) begin
      s_nxt.rx_st  = ECH_CH_RUN;
      s_nxt.rx_cnt = 14'h0000;
    end
    if (i_rd_en) begin
      unique case (i_addr)
        `ECH_ADDR_CFG:    s_nxt.rd_data = {16'h0000, s_r.cfg};
        `ECH_ADDR_RXCCT:  s_nxt.rd_data = {16'h0000, s_r.cct};
        `ECH_ADDR_STATUS: s_nxt.rd_data = {16'h0000, s_r.pend[7:0], s_r.locked, s_r.oof_q,
                                           o_intersystem_link_protocol, 1'b0, s_r.rx_st, s_r.tx_st};
        default:          s_nxt.rd_data = 32'h0000_0000;
      endcase
    end

    // buffer length counting, next descriptor on end
    if (tx_run & i_tx_octet) begin
      s_nxt.tx_cnt = s_r.tx_cnt + 14'h0001;
    end
    if (tx_done) begin
      s_nxt.tx_cnt  = 14'h0000;
      s_nxt.tx_next = 1'b1;
    end
    if (rx_run & i_rx_octet) begin
      s_nxt.rx_cnt = s_r.rx_cnt + 14'h0001;
    end
    if (rx_done) begin
      s_nxt.rx_cnt = 14'h0000;
    end

    // transmit errors stop the channel
    if (tx_onr | tx_fifo_run_error) begin
      s_nxt.tx_st = ECH_CH_SUSP;
    end

    // receive errors
    if (rx_onr) begin
      s_nxt.rx_st    = ECH_CH_OFF;
      s_nxt.rx_flush = 1'b1;
    end else if (rx_fifo_run_error) begin
      s_nxt.rx_st    = ECH_CH_SUSP;
      s_nxt.rx_flush = 1'b1;
    end

    // link clock edges and frame flywheel
    s_nxt.lclk_q = sy[0];
    if (lclk_rise) begin
      s_nxt.receive_frame_sync_q = sy[1];
      if (!framed) begin
        s_nxt.locked  = 1'b0;
        s_nxt.bit_cnt = 11'h000;
      end else if (sync_rise) begin
        s_nxt.locked  = 1'b1;
        s_nxt.bit_cnt = 11'h000;
      end else begin
        s_nxt.bit_cnt = (s_r.bit_cnt >= frm_last) ? 11'h000 : s_r.bit_cnt + 11'h001;
      end
    end
    if (alignment_change_error & abort & (s_nxt.rx_st != ECH_CH_OFF)) begin
      s_nxt.rx_st    = ECH_CH_SUSP;
      s_nxt.rx_flush = 1'b1;
    end

    // frame loss tracking
    s_nxt.oof_q = sy[2];
    if (oof_rise) begin
      s_nxt.rx_flush = 1'b1;
      if (abort & (s_nxt.rx_st != ECH_CH_OFF)) begin
        s_nxt.rx_st = ECH_CH_SUSP;
      end
    end

    // descriptor poster, lowest index first
    if (!s_r.idv || i_idesc_ready) begin
      s_nxt.idv = 1'b0;
      for (int k = `ECH_NPEND - 1; k >= 0; k--) begin
        if (s_r.pend[k]) begin
          s_nxt.idv = 1'b1;
          ev_clr    = '0;
          ev_clr[k] = 1'b1;
        end
      end
      unique case (1'b1)
        ev_clr[`ECH_P_TXEOB]:  {s_nxt.idcode, s_nxt.iddir} = {ECH_C_EOB, `ECH_DIR_TX};
        ev_clr[`ECH_P_RXEOB]:  {s_nxt.idcode, s_nxt.iddir} = {ECH_C_EOB, `ECH_DIR_RX};
        ev_clr[`ECH_P_FRAME_RECOVERED_EVENT]:   {s_nxt.idcode, s_nxt.iddir} = {ECH_C_FRAME_RECOVERED_EVENT, `ECH_DIR_RX};
        ev_clr[`ECH_P_TXONR]:  {s_nxt.idcode, s_nxt.iddir} = {ECH_C_ONR, `ECH_DIR_TX};
        ev_clr[`ECH_P_TXBUFF]: {s_nxt.idcode, s_nxt.iddir} = {ECH_C_FIFO_RUN_ERROR, `ECH_DIR_TX};
        ev_clr[`ECH_P_RXONR]:  {s_nxt.idcode, s_nxt.iddir} = {ECH_C_ONR, `ECH_DIR_RX};
        ev_clr[`ECH_P_RXBUFF]: {s_nxt.idcode, s_nxt.iddir} = {ECH_C_FIFO_RUN_ERROR, `ECH_DIR_RX};
        ev_clr[`ECH_P_ALIGNMENT_CHANGE_ERROR]:   {s_nxt.idcode, s_nxt.iddir} = {ECH_C_ALIGNMENT_CHANGE_ERROR, `ECH_DIR_RX};
        ev_clr[`ECH_P_OOF]:    {s_nxt.idcode, s_nxt.iddir} = {ECH_C_OOF, `ECH_DIR_RX};
        default: ; // no message-end code exists
      endcase
    end
    // new events win over the clear of the same bit
    s_nxt.pend = (s_r.pend & ~ev_clr) | ev_set;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      s_r <= RST;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  assign o_rd_data                   = s_r.rd_data;
  assign o_tx_next_desc              = s_r.tx_next;
  assign o_tx_idle_code              = ~tx_run;
  assign o_tx_bus_en                 = tx_run;
  assign o_rx_next_desc              = rx_done;
  assign o_rx_bus_en                 = rx_run & ~(s_r.oof_q & abort);
  assign o_rx_store_en               = rx_run & ~(s_r.oof_q & abort);
  assign o_rx_fill_ones              = rx_run & s_r.oof_q & ~abort;
  assign o_rx_flush                  = s_r.rx_flush;
  assign o_intersystem_link_protocol = (s_r.cfg[`ECH_F_FCS] == `ECH_FCS_INTERSYSTEM_LINK_PROTOCOL) &&
                                       (s_r.cfg[`ECH_F_PROTO_HI:`ECH_F_PROTO_LO] == `ECH_PROTO_INTERSYSTEM_LINK_PROTOCOL);
  assign o_idesc_valid               = s_r.idv;
  assign o_idesc_chan                = s_r.cfg[`ECH_F_CHAN_HI:`ECH_F_CHAN_LO];
  assign o_idesc_code                = s_r.idcode;
  assign o_idesc_dir                 = s_r.iddir;

  property p_tx_eob;
    @(posedge i_clk_sys) disable iff (i_reset)
    (i_ce && tx_done && i_tx_buffer_end_event_enable) |=> s_r.pend[`ECH_P_TXEOB];
  endproperty
  a_tx_eob: assert property (p_tx_eob) else $error("tx buffer end not raised");
  property p_no_eom;
    @(posedge i_clk_sys) disable iff (i_reset)
    o_idesc_valid |-> (o_idesc_code inside {ECH_C_EOB, ECH_C_FRAME_RECOVERED_EVENT, ECH_C_ONR, ECH_C_FIFO_RUN_ERROR, ECH_C_ALIGNMENT_CHANGE_ERROR, ECH_C_OOF});
  endproperty
  a_no_eom: assert property (p_no_eom) else $error("illegal descriptor code");
  property p_tx_next;
    @(posedge i_clk_sys) disable iff (i_reset)
    (i_ce && tx_done) |=> (o_tx_next_desc && s_r.tx_cnt == 14'h0000);
  endproperty
  a_tx_next: assert property (p_tx_next) else $error("no next descriptor step");
  property p_rx_eob;
    @(posedge i_clk_sys) disable iff (i_reset)
    (i_ce && rx_done && i_rx_buffer_end_event_enable) |=> s_r.pend[`ECH_P_RXEOB];
  endproperty
  a_rx_eob: assert property (p_rx_eob) else $error("rx buffer end not raised");
  property p_frame_recovered_event;
    @(posedge i_clk_sys) disable iff (i_reset)
    (i_ce && oof_fall && !s_r.cfg[`ECH_F_MASK]) |=> s_r.pend[`ECH_P_FRAME_RECOVERED_EVENT];
  endproperty
  a_frame_recovered_event: assert property (p_frame_recovered_event) else $error("frame recovery not raised");
  property p_tx_onr;
    @(posedge i_clk_sys) disable iff (i_reset)
    (i_ce && tx_run && i_tx_desc_fetch && !i_tx_dev_owns && !i_wr_en)
      |=> (s_r.tx_st == ECH_CH_SUSP && !o_tx_bus_en && s_r.pend[`ECH_P_TXONR]);
  endproperty
  a_tx_onr: assert property (p_tx_onr) else $error("tx ownership error mishandled");
  property p_tx_fifo_run_error;
    @(posedge i_clk_sys) disable iff (i_reset)
    (i_ce && tx_fifo_run_error && !i_wr_en) |=> (o_tx_idle_code && s_r.pend[`ECH_P_TXBUFF]);
  endproperty
  a_tx_fifo_run_error: assert property (p_tx_fifo_run_error) else $error("tx underrun mishandled");
  property p_rx_onr;
    @(posedge i_clk_sys) disable iff (i_reset)
    (i_ce && rx_onr && !rx_restart) |=> (s_r.rx_st == ECH_CH_OFF && o_rx_flush);
  endproperty
  a_rx_onr: assert property (p_rx_onr) else $error("rx ownership error mishandled");
  property p_rx_fifo_run_error;
    @(posedge i_clk_sys) disable iff (i_reset)
    (i_ce && rx_fifo_run_error && !rx_restart) |=> (s_r.rx_st == ECH_CH_SUSP && o_rx_flush && !o_rx_bus_en);
  endproperty
  a_rx_fifo_run_error: assert property (p_rx_fifo_run_error) else $error("rx overrun mishandled");

  property p_intersystem_link_protocol;
    @(posedge i_clk_sys) disable iff (i_reset)
    (i_ce && i_wr_en && i_addr == `ECH_ADDR_CFG && i_wr_data[`ECH_F_FCS] &&
     i_wr_data[`ECH_F_PROTO_HI:`ECH_F_PROTO_LO] == `ECH_PROTO_INTERSYSTEM_LINK_PROTOCOL) |=> o_intersystem_link_protocol;
  endproperty
  a_intersystem_link_protocol: assert property (p_intersystem_link_protocol) else $error("link protocol not selected");

  property p_dir;
    @(posedge i_clk_sys) disable iff (i_reset)
    (o_idesc_valid && o_idesc_code inside {ECH_C_FRAME_RECOVERED_EVENT, ECH_C_ALIGNMENT_CHANGE_ERROR, ECH_C_OOF}) |-> o_idesc_dir == `ECH_DIR_RX;
  endproperty
  a_dir: assert property (p_dir) else $error("wrong descriptor direction");

  c_alignment_change_error: cover property (@(posedge i_clk_sys) disable iff (i_reset) i_ce && alignment_change_error);
  c_oof:  cover property (@(posedge i_clk_sys) disable iff (i_reset) i_ce && oof_rise && rx_run);
  c_post: cover property (@(posedge i_clk_sys) disable iff (i_reset) o_idesc_valid && i_idesc_ready);
  c_eob:  cover property (@(posedge i_clk_sys) disable iff (i_reset) i_ce && tx_done);

endmodule : ech_handler

`default_nettype wire

// file: hdl/ech_cfg.svh
// register map, field positions, reset values and framing counts
`ifndef ECH_CFG_SVH
`define ECH_CFG_SVH

`define ECH_ADDR_W       4
`define ECH_ADDR_CFG     4'h0
`define ECH_ADDR_CMD     4'h4
`define ECH_ADDR_RXCCT   4'h8
`define ECH_ADDR_STATUS  4'hC

`define ECH_F_CHAN_HI    7
`define ECH_F_CHAN_LO    0
`define ECH_F_PROTO_HI   9
`define ECH_F_PROTO_LO   8
`define ECH_F_FCS        10
`define ECH_F_ABORT      11
`define ECH_F_MASK       12
`define ECH_F_MODE_HI    15
`define ECH_F_MODE_LO    13

`define ECH_CMD_TXACT    0
`define ECH_CMD_RXACT    1
`define ECH_CMD_RXJUMP   2

`define ECH_CFG_RST      16'h0000
`define ECH_CCT_RST      16'h0000

`define ECH_PROTO_INTERSYSTEM_LINK_PROTOCOL   2'h2
`define ECH_FCS_INTERSYSTEM_LINK_PROTOCOL     1'b1
`define ECH_DIR_TX       1'b1
`define ECH_DIR_RX       1'b0

`define ECH_MODE_T1      3'h1
`define ECH_MODE_E1      3'h2
`define ECH_MODE_E1X2    3'h3
`define ECH_MODE_E1X4    3'h4
`define ECH_FRM_T1       11'h0C1
`define ECH_FRM_E1       11'h100
`define ECH_FRM_E1X2     11'h200
`define ECH_FRM_E1X4     11'h400

`define ECH_P_TXEOB      0
`define ECH_P_RXEOB      1
`define ECH_P_FRAME_RECOVERED_EVENT       2
`define ECH_P_TXONR      3
`define ECH_P_TXBUFF     4
`define ECH_P_RXONR      5
`define ECH_P_RXBUFF     6
`define ECH_P_ALIGNMENT_CHANGE_ERROR       7
`define ECH_P_OOF        8
`define ECH_NPEND        9

`endif

// file: hdl/ech_pkg.sv
// types of the channel event and error handler
package ech_pkg;

  typedef enum logic [1:0] {
    ECH_CH_OFF  = 2'h0,
    ECH_CH_RUN  = 2'h1,
    ECH_CH_SUSP = 2'h3
  } ech_ch_e;

  typedef enum logic [3:0] {
    ECH_C_NONE = 4'h0,
    ECH_C_EOB  = 4'h1,
    ECH_C_FRAME_RECOVERED_EVENT = 4'h2,
    ECH_C_ONR  = 4'h3,
    ECH_C_FIFO_RUN_ERROR = 4'h4,
    ECH_C_ALIGNMENT_CHANGE_ERROR = 4'h5,
    ECH_C_OOF  = 4'h6
  } ech_code_e;

  typedef struct packed {
    ech_ch_e     tx_st;
    ech_ch_e     rx_st;
    logic [13:0] tx_cnt;
    logic [13:0] rx_cnt;
    logic [8:0]  pend;
    logic        idv;
    ech_code_e   idcode;
    logic        iddir;
    logic        tx_next;
    logic        rx_flush;
    logic        lclk_q;
    logic        receive_frame_sync_q;
    logic        oof_q;
    logic        locked;
    logic [10:0] bit_cnt;
    logic [15:0] cfg;
    logic [15:0] cct;
    logic [31:0] rd_data;
  } ech_state_s;

endpackage : ech_pkg

// file: hdl/ech_sync.sv
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module ech_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_reset,
  input  wire logic         i_ce,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ech_sync_s;

  ech_sync_s s_r;
  ech_sync_s s_nxt;

  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = i_async;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      s_r <= '0;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  assign o_sync = s_r.s2;

endmodule : ech_sync

`default_nettype wire

// file: verification/ech_host_model.sv
// host model that takes interrupt descriptors, promptly or stalling
`timescale 1ns/1ps
`default_nettype none

module ech_host_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  input  wire logic        i_slow,
  input  wire logic        i_valid,
  input  wire logic [7:0]  i_chan,
  input  wire logic [3:0]  i_code,
  input  wire logic        i_dir,
  output logic             o_ready,
  output logic             o_take,
  output logic      [12:0] o_desc
);
  logic [1:0] stall_r;

  assign o_take = i_valid && o_ready;
  assign o_desc = {i_chan, i_code, i_dir};

  // slow host accepts only every fourth cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      stall_r <= 2'h0;
      o_ready <= 1'b0;
    end else begin
      stall_r <= stall_r + 2'h1;
      o_ready <= !i_slow || (stall_r == 2'h3);
    end
  end
endmodule : ech_host_model

`default_nettype wire

// file: verification/ech_handler_tb_top.sv
// self-checking bench of the channel event and error handler
`timescale 1ns/1ps
`default_nettype none

module ech_handler_tb_top;
  logic        clk, rst, wr_en, rd_en, lclk, receive_frame_sync, floss, slow;
  logic [3:0]  addr;
  logic [31:0] wdata, rd_data, seed, v;
  logic        tx_oct, tx_eobe, tx_fetch, tx_owns, tx_empty, tx_need;
  logic        rx_oct, rx_eobe, rx_ovf, rx_owns;
  logic [13:0] tx_len, rx_len;
  logic        tx_nd, tx_idle, tx_bus, rx_nd, rx_bus, rx_store, rx_ones, rx_fl, intersystem_link_protocol;
  logic        iv, ird, idir, take;
  logic [7:0]  ichan, ch;
  logic [3:0]  icode;
  logic [12:0] desc;
  logic [12:0] exp_q[$];
  int          miscompares, checks_done, flushes;

  ech_handler u_ech_handler (
    .i_clk_sys(clk), .i_reset(rst), .i_ce(1'b1), .i_addr(addr), .i_wr_data(wdata),
    .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rd_data), .i_link_clk(lclk),
    .i_receive_frame_sync(receive_frame_sync), .i_frame_loss(floss), .i_tx_octet(tx_oct),
    .i_tx_buffer_length_field(tx_len), .i_tx_buffer_end_event_enable(tx_eobe),
    .i_tx_desc_fetch(tx_fetch), .i_tx_dev_owns(tx_owns), .i_tx_fifo_empty(tx_empty),
    .i_tx_bit_need(tx_need), .i_rx_octet(rx_oct), .i_rx_buffer_length_field(rx_len),
    .i_rx_buffer_end_event_enable(rx_eobe), .i_rx_fifo_ovf(rx_ovf), .i_rx_dev_owns(rx_owns),
    .o_tx_next_desc(tx_nd), .o_tx_idle_code(tx_idle), .o_tx_bus_en(tx_bus),
    .o_rx_next_desc(rx_nd), .o_rx_bus_en(rx_bus), .o_rx_store_en(rx_store),
    .o_rx_fill_ones(rx_ones), .o_rx_flush(rx_fl), .o_intersystem_link_protocol(intersystem_link_protocol),
    .o_idesc_valid(iv), .i_idesc_ready(ird), .o_idesc_chan(ichan), .o_idesc_code(icode),
    .o_idesc_dir(idir));

  ech_host_model u_ech_host_model (
    .i_clk_sys(clk), .i_reset(rst), .i_slow(slow), .i_valid(iv), .i_chan(ichan),
    .i_code(icode), .i_dir(idir), .o_ready(ird), .o_take(take), .o_desc(desc));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] r);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    r = rd_data;
    @(posedge clk);
  endtask : rd

  // wait until every expected descriptor was taken by the host
  task automatic drain();
    int n;
    n = 0;
    @(posedge clk);
    seed = lfsr(seed);
    slow <= seed[0];
    while (exp_q.size() != 0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (exp_q.size() != 0) chk(32'h1, 32'h0);
    repeat (8) @(posedge clk);
  endtask : drain

  task automatic rx_state(input logic [1:0] st);
    rd(4'hC, v);
    chk(32'(v[3:2]), 32'(st));
  endtask : rx_state

  // frame sync pulse of two link bits, then ten link bits of quiet
  task automatic sync_pulse();
    receive_frame_sync <= 1'b1;
    repeat (20) @(posedge clk);
    receive_frame_sync <= 1'b0;
    repeat (100) @(posedge clk);
  endtask : sync_pulse

  always @(posedge clk) begin
    if (rx_fl) flushes++;
    if (take) begin
      if (exp_q.size() == 0) chk(32'(desc), 32'hFFFFFFFF);
      else chk(32'(desc), 32'(exp_q.pop_front()));
    end
  end

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    lclk = 1'b0;
    forever #40 lclk = ~lclk;
  end

  initial begin
    #400000;
    miscompares++;
    end_sim();
  end

  initial begin
    {rst, wr_en, rd_en, receive_frame_sync, floss, slow, tx_oct, tx_eobe, tx_fetch, tx_owns} = '0;
    {tx_empty, tx_need, rx_oct, rx_eobe, rx_ovf, rx_owns} = '0;
    {addr, wdata, tx_len, rx_len} = '0;
    miscompares = 0;
    checks_done = 0;
    flushes     = 0;
    seed = 32'hec9a93b1;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(4'hC, v);
    chk(32'(v[3:0]), 32'h0);
    chk(32'(tx_idle), 32'h1);
    rd(4'h2, v);
    chk(v, 32'h0);
    seed = lfsr(seed);
    ch = seed[7:0];
    wr(4'h0, {16'h0, 8'h02, ch});
    @(negedge clk);
    chk(32'(intersystem_link_protocol), 32'h0);
    wr(4'h0, {16'h0, 8'h06, ch});
    @(negedge clk);
    chk(32'(intersystem_link_protocol), 32'h1);
    rd(4'h0, v);
    chk(v, {16'h0, 8'h06, ch});
    tx_owns <= 1'b1;
    rx_owns <= 1'b1;
    wr(4'h4, 32'h3);
    // transmit buffer ends, with and without event
    for (int e = 1; e >= 0; e--) begin
      if (e == 1) exp_q.push_back({ch, 4'h1, 1'b1});
      tx_len  <= 14'h3;  // no message-end bit is ever driven
      tx_eobe <= e[0];
      for (int k = 0; k < 3; k++) begin
        @(posedge clk);
        tx_oct <= 1'b1;
      end
      @(posedge clk);
      tx_oct <= 1'b0;
      @(negedge clk);
      chk(32'(tx_nd), 32'h1);
      drain();
    end
    exp_q.push_back({ch, 4'h1, 1'b0});
    rx_len  <= 14'h2;
    rx_eobe <= 1'b1;
    @(posedge clk);
    rx_oct <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk(32'(rx_nd), 32'h1);
    @(posedge clk);
    rx_oct <= 1'b0;
    drain();
    // host-owned transmit buffer, then fifo underrun
    for (int s = 0; s < 2; s++) begin
      exp_q.push_back({ch, s ? 4'h4 : 4'h3, 1'b1});
      @(posedge clk);
      tx_owns  <= s[0];
      tx_fetch <= !s[0];
      tx_empty <= s[0];
      tx_need  <= s[0];
      @(posedge clk);
      {tx_fetch, tx_empty, tx_need} <= 3'h0;
      drain();
      chk(32'({tx_idle, tx_bus}), 32'h2);
      tx_owns <= 1'b1;
      wr(4'h4, 32'h1);
      @(negedge clk);
      chk(32'({tx_idle, tx_bus}), 32'h1);
    end
    // receive overflow without and with buffer
    for (int s = 0; s < 2; s++) begin
      exp_q.push_back({ch, s ? 4'h4 : 4'h3, 1'b0});
      @(posedge clk);
      rx_owns <= s[0];
      rx_ovf  <= 1'b1;
      @(posedge clk);
      rx_ovf <= 1'b0;
      drain();
      chk(32'(rx_bus), 32'h0);
      rx_state(s ? 2'h3 : 2'h0);
      rx_owns <= 1'b1;
      seed = lfsr(seed);
      if (s == 0) wr(4'h8, {16'h0, seed[15:0]});
      else wr(4'h4, 32'h4);
      rx_state(2'h1);
    end
    // frame loss, without then with abort
    for (int a = 0; a < 2; a++) begin
      wr(4'h0, {16'h0, a ? 8'h0E : 8'h06, ch});
      exp_q.push_back({ch, 4'h6, 1'b0});
      @(posedge clk);
      floss <= 1'b1;
      drain();
      chk(32'({rx_bus, rx_ones, rx_store}), a ? 32'h0 : 32'h7);
      exp_q.push_back({ch, 4'h2, 1'b0});
      @(posedge clk);
      floss <= 1'b0;
      drain();
      chk(32'(rx_ones), 32'h0);
      rx_state(a ? 2'h3 : 2'h1);
      if (a == 1) wr(4'h4, 32'h2);
      rx_state(2'h1);
    end
    // alignment change in E1 mode, without then with abort
    for (int a = 0; a < 2; a++) begin
      wr(4'h0, {16'h0, a ? 8'h4E : 8'h46, ch});
      sync_pulse();
      exp_q.push_back({ch, 4'h5, 1'b0});
      sync_pulse();
      drain();
      rx_state(a ? 2'h3 : 2'h1);
      wr(4'h4, 32'h2);
      wr(4'h0, {16'h0, 8'h06, ch});
      repeat (20) @(posedge clk);
    end
    chk(32'(flushes), 32'h5);
    end_sim();
  end
endmodule : ech_handler_tb_top

`default_nettype wire
